// *** rtl/dram_refresh_consts.vh ***
// Constants for the refresh and arbitration controller of a 64K x 1 dynamic RAM
`ifndef DRAM_REFRESH_CONSTS_VH
`define DRAM_REFRESH_CONSTS_VH

`define CLK_PERIOD_NS 25
`define ROW_COUNT 128
`define REFRESH_PERIOD_NS 2000000
// Interval per row, rounded down so 128 rows fit in 2 ms
`define REF_INTERVAL_CYC ((`REFRESH_PERIOD_NS / `ROW_COUNT) / `CLK_PERIOD_NS)
`define PRECHARGE_NS 100
`define PRECHARGE_CYC ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_NS 250
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXIT_DELAY_NS 250
`define EXIT_DELAY_CYC ((`EXIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W 10
`define CNT_W 4
`define ONE_TIMER 10'h001
`define ZERO_TIMER 10'h000
`define ONE_CNT 4'h1
`define ZERO_CNT 4'h0
// Unit step for 32-bit load arithmetic before it is cut to a counter's width
`define ONE_WORD 32'h00000001

`endif

// *** rtl/dram_refresh_pin_control.v ***
// Refresh timer, arbiter and pin sequencer driving a 64K x 1 dynamic RAM
`timescale 1ns/10ps
`include "dram_refresh_consts.vh"

module dram_refresh_pin_control (
	input wire MCLK, // 40 MHz clock
	input wire RST_N, // Synchronous reset, active low
	input wire HOST_MEM_REQ, // Host memory request level, held until done
	input wire SERIAL_OUT_SELECT, // High selects boot ROM in overlap space
	input wire SELF_REFRESH_REQ, // Level: hold memory in self refresh
	output wire HOST_GRANT, // Host owns the memory this cycle
	output wire HOST_DONE, // One-cycle pulse, host access finished
	output reg RAS_N, // Row strobe to RAM, active low
	output reg REF_N, // Refresh pin to RAM, active low
	output reg ROM_SELECT, // Boot ROM enabled in overlap space
	output reg RAM_SELECT, // RAM enabled in overlap space
	output reg IN_SELF_REFRESH // Memory held in self refresh or in its exit delay
);

	localparam ST_IDLE = 5'h01;
	localparam ST_ACCESS = 5'h02;
	localparam ST_AUTO = 5'h04;
	localparam ST_SELF = 5'h08;
	localparam ST_EXIT = 5'h10;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	wire req_s2_q;
	wire sel_s2_q;
	wire slf_s2_q;
	// Two flops each, since the host runs off its own timing
	pin_sync #(.RESET_VAL(1'h0)) req_sync (
		.clk(MCLK),
		.rst_n(RST_N),
		.pin(HOST_MEM_REQ),
		.sync_q(req_s2_q)
	);
	// Select resets high so the boot ROM is mapped while the host starts up
	pin_sync #(.RESET_VAL(1'h1)) sel_sync (
		.clk(MCLK),
		.rst_n(RST_N),
		.pin(SERIAL_OUT_SELECT),
		.sync_q(sel_s2_q)
	);
	// Self refresh request resets low so the first cycles stay normal
	pin_sync #(.RESET_VAL(1'h0)) slf_sync (
		.clk(MCLK),
		.rst_n(RST_N),
		.pin(SELF_REFRESH_REQ),
		.sync_q(slf_s2_q)
	);

	// ------------------------------------------------------------
	// Refresh interval timer
	// ------------------------------------------------------------
	reg [`TIMER_W-1:0] timer_q;
	reg pend_q;
	reg [4:0] state_q, state_d;
	reg [`CNT_W-1:0] cnt_q, cnt_d;
	wire tick = (timer_q == `ZERO_TIMER);
	wire refresh_taken = (state_q == ST_IDLE) && (state_d == ST_AUTO);
	// Load values come from 32-bit macro arithmetic; only the low bits are kept,
	// and every one of them fits the counter it is loaded into
	wire [31:0] timer_reload_w = `REF_INTERVAL_CYC - `ONE_WORD;
	wire [31:0] pre_load_w = `PRECHARGE_CYC - `ONE_WORD;
	wire [31:0] acc_load_w = `ACCESS_CYC - `ONE_WORD;
	wire [31:0] exit_load_w = `EXIT_DELAY_CYC - `ONE_WORD;
	wire [31:0] rest_load_w = `PRECHARGE_CYC;
	// Free running, so requests come regardless of host state
	always @(posedge MCLK) begin
		if (!RST_N) begin
			timer_q <= `ZERO_TIMER;
			pend_q <= 1'b0;
		end else begin
			if (tick)
				timer_q <= timer_reload_w[`TIMER_W-1:0];
			else
				timer_q <= timer_q - `ONE_TIMER;
			// A new tick wins over taking the old request
			if (tick)
				pend_q <= 1'b1;
			else if (refresh_taken)
				pend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Row strobe precharge guard
	// ------------------------------------------------------------
	reg [`CNT_W-1:0] rest_q;
	wire rested = (rest_q == `ZERO_CNT);
	// Counts the precharge after every access, so neither a refresh nor the
	// next access lowers a pin before the row strobe has recovered
	// It also outlasts the host's two-flop lag, so a request dropped on the
	// done pulse is not mistaken for a second one
	always @(posedge MCLK) begin
		if (!RST_N) begin
			rest_q <= `ZERO_CNT;
		end else if (state_d == ST_ACCESS) begin
			rest_q <= rest_load_w[`CNT_W-1:0];
		end else if (!rested) begin
			rest_q <= rest_q - `ONE_CNT;
		end
	end

	// ------------------------------------------------------------
	// Arbiter and pin sequencer
	// ------------------------------------------------------------
	// Automatic refresh uses the RAM's own row counter, so no external
	// counter exists and self refresh never mixes with it
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			ST_IDLE: begin
				// Refresh first on a tie
				if (!rested) begin
					// Row strobe still precharging from the last access
					state_d = ST_IDLE;
				end else if (slf_s2_q) begin
					state_d = ST_SELF;
				end else if (pend_q) begin
					state_d = ST_AUTO;
					cnt_d = pre_load_w[`CNT_W-1:0];
				end else if (req_s2_q) begin
					state_d = ST_ACCESS;
					cnt_d = acc_load_w[`CNT_W-1:0];
				end
			end
			ST_ACCESS: begin
				// Runs to completion, never cut short by refresh
				if (cnt_q == `ZERO_CNT)
					state_d = ST_IDLE;
				else
					cnt_d = cnt_q - `ONE_CNT;
			end
			ST_AUTO: begin
				// Refresh pin low for one precharge time
				if (cnt_q == `ZERO_CNT)
					state_d = ST_IDLE;
				else
					cnt_d = cnt_q - `ONE_CNT;
			end
			ST_SELF: begin
				// RAM times its own rows while we hold the pin
				if (!slf_s2_q) begin
					state_d = ST_EXIT;
					cnt_d = exit_load_w[`CNT_W-1:0];
				end
			end
			ST_EXIT: begin
				// Exit delay before any access
				if (cnt_q == `ZERO_CNT)
					state_d = ST_IDLE;
				else
					cnt_d = cnt_q - `ONE_CNT;
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d = `ZERO_CNT;
			end
		endcase
	end

	always @(posedge MCLK) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
			cnt_q <= `ZERO_CNT;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// ------------------------------------------------------------
	// Registered pins, and the host grant and done decoded from state
	// ------------------------------------------------------------
	// Row strobe only for access, refresh pin only for refresh
	always @(posedge MCLK) begin
		if (!RST_N) begin
			RAS_N <= 1'b1;
			REF_N <= 1'b1;
			ROM_SELECT <= 1'b1;
			RAM_SELECT <= 1'b0;
			IN_SELF_REFRESH <= 1'b0;
		end else begin
			RAS_N <= !(state_d == ST_ACCESS);
			REF_N <= !((state_d == ST_AUTO) || (state_d == ST_SELF));
			ROM_SELECT <= sel_s2_q;
			RAM_SELECT <= !sel_s2_q;
			IN_SELF_REFRESH <= (state_d == ST_SELF) || (state_d == ST_EXIT);
		end
	end

	assign HOST_GRANT = (state_q == ST_ACCESS);
	assign HOST_DONE = (state_q == ST_ACCESS) && (cnt_q == `ZERO_CNT);

	// Synchronous opcode-fetch refresh and RAS-only refresh are not built:
	// the pin scheme covers them without an address mux

endmodule

// ------------------------------------------------------------
// Two-flop synchroniser for one asynchronous pin
// ------------------------------------------------------------
module pin_sync #(
	parameter [0:0] RESET_VAL = 1'h0
) (
	input wire clk, // Sampling clock
	input wire rst_n, // Synchronous reset, active low
	input wire pin, // Asynchronous level in
	output reg sync_q // Level after two flops
);
	reg meta_q;
	// Only the second flop is read, so a metastable first flop stays inside
	always @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
		end
	end
endmodule

// *** verification/dram_model.sv ***
// Refresh side model of the dynamic RAM
`timescale 1ns/10ps
module dram_model (
	input wire logic RAS_N, // Row strobe
	input wire logic REF_N, // Refresh pin
	output logic [6:0] ROW // Refresh row
);
	// Row steps at refresh end, or every 14 us while held low
	initial ROW = 7'h00;
	always @(posedge REF_N) if (RAS_N) ROW <= ROW + 7'h01;
	always #14000 if (!REF_N && RAS_N) ROW <= ROW + 7'h01;
endmodule

// *** verification/refresh_checker.sv ***
// Port assertions for the refresh pin controller
`timescale 1ns/10ps
module refresh_checker (
	input wire logic MCLK, // Clock
	input wire logic RST_N, // Reset
	input wire logic HOST_GRANT, // Grant
	input wire logic HOST_DONE, // Done
	input wire logic RAS_N, // Strobe
	input wire logic REF_N, // Refresh
	input wire logic ROM_SELECT, // ROM map
	input wire logic RAM_SELECT, // RAM map
	input wire logic IN_SELF_REFRESH // Self
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Strobe use, refresh width and the self refresh lockout
	one_owner_a: assert property (RAS_N || REF_N) else $error("overlap");
	strobe_use_a: assert property (RAS_N == !HOST_GRANT) else $error("strobe");
	map_excl_a: assert property (ROM_SELECT ^ RAM_SELECT) else $error("map");
	ref_width_a: assert property ($fell(REF_N) && !IN_SELF_REFRESH |->
		!REF_N[*4] ##1 REF_N) else $error("width");
	access_len_a: assert property ($rose(HOST_GRANT) |->
		HOST_GRANT[*8] ##1 (HOST_GRANT && !HOST_DONE) ##1
		(HOST_GRANT && HOST_DONE) ##1 !HOST_GRANT) else $error("access");
	done_once_a: assert property (HOST_DONE |=> !HOST_DONE) else $error("done");
	exit_wait_a: assert property ($rose(REF_N) && IN_SELF_REFRESH |->
		RAS_N[*8] ##1 RAS_N ##1 RAS_N) else $error("exit");
	self_lock_a: assert property (IN_SELF_REFRESH |-> RAS_N) else $error("self");
endmodule

bind dram_refresh_pin_control refresh_checker chk_i (.*);

// *** verification/dram_refresh_pin_control_bench.sv ***
// Bench for the refresh pin controller
`timescale 1ns/10ps
module dram_refresh_pin_control_bench;
	logic MCLK = 0, RST_N = 0, HOST_MEM_REQ = 0, SERIAL_OUT_SELECT = 1, SELF_REFRESH_REQ = 0;
	wire HOST_GRANT, HOST_DONE, RAS_N, REF_N, ROM_SELECT, RAM_SELECT, IN_SELF_REFRESH;
	wire [6:0] mem_row;
	logic [6:0] r0;
	int err_total = 0, cmp_count = 0;
	time t0;
	dram_refresh_pin_control uut (.*);
	dram_model mem (.RAS_N(RAS_N), .REF_N(REF_N), .ROW(mem_row));
	// 40 MHz clock
	initial forever #12.5 MCLK = ~MCLK;
	task chk(string s, logic [15:0] g, logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task wrap_up;
		$display("cmp %0d err %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task cyc(int k);
		repeat (k) @(posedge MCLK);
	endtask
	// Whole cycles since t0; every event used lands on a clock edge
	function logic [15:0] el();
		return 16'(($time - t0) / 25);
	endfunction
	// Auto refresh width and spacing
	task t_refresh;
		@(negedge REF_N);
		t0 = $time;
		r0 = mem_row;
		@(posedge REF_N);
		chk("width", el(), 16'h0004);
		@(negedge REF_N);
		chk("spacing", el(), 16'h0271);
		chk("row step", {9'h000, mem_row}, {9'h000, r0 + 7'h01});
	endtask
	// Request landing in a refresh waits, then gets one whole access
	task t_host;
		HOST_MEM_REQ <= 1;
		@(negedge RAS_N);
		t0 = $time;
		chk("order", {15'h0000, REF_N}, 16'h0001);
		@(posedge HOST_DONE);
		HOST_MEM_REQ <= 0;
		@(posedge RAS_N);
		chk("access", el(), 16'h000A);
	endtask
	// Self refresh locks the host out until the exit delay is over
	task t_self;
		SELF_REFRESH_REQ <= 1;
		SERIAL_OUT_SELECT <= 0;
		cyc(6);
		HOST_MEM_REQ <= 1;
		cyc(20);
		chk("self", {IN_SELF_REFRESH, REF_N, RAS_N, ROM_SELECT, RAM_SELECT}, 16'h0015);
		SELF_REFRESH_REQ <= 0;
		@(posedge REF_N);
		t0 = $time;
		@(negedge RAS_N);
		chk("exit", {15'h0000, el() > 16'h0009}, 16'h0001);
		@(posedge HOST_DONE);
		HOST_MEM_REQ <= 0;
	endtask
	// Reset values, then the scenarios in turn
	initial begin
		cyc(20);
		chk("reset", {RAS_N, REF_N, ROM_SELECT, RAM_SELECT, IN_SELF_REFRESH}, 16'h001C);
		RST_N <= 1;
		t_refresh();
		t_host();
		cyc(4);
		t_self();
		wrap_up();
	end
	// Watchdog against a hung handshake
	initial begin
		cyc(5000);
		err_total++;
		wrap_up();
	end
endmodule
